/* cwd_core.sv */
// Dead-band core of the complementary waveform generator
`timescale 1ns/1ps
`include "cwd_defines.svh"
module cwd_core import cwd_pkg::*; (
	input  wire logic         core_clk_i,    // 40 MHz system clock
	input  wire logic         rst_i,         // Synchronous, active high
	input  wire cwd_bus_req_t bus_i,         // Register port request
	output logic        [7:0] rdata_o,       // Read data, next cycle
	input  wire logic  [13:0] src_i,         // On-chip data sources
	input  wire logic         osc_clk_i,     // 16 MHz fast oscillator
	input  wire logic         sleep_i,       // Device in sleep
	input  wire logic         shutdown_i,    // Shutdown from outside
	output logic              osc_keep_on_o, // Keep oscillator running
	output cwd_drive_t        drive_o        // Four output drives
);
	////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic       en;       // Module enable
		logic       en_prev;  // Enable one cycle ago
		logic       ld;       // Buffer-load request pending
		logic       ld_armed; // Falling edge seen after request
		cwd_mode_t  mode;     // Operating mode
		logic [3:0] pol;      // Output polarity bits
		logic [3:0] sel;      // Input source select
		logic       cs;       // Dead-band clock select
		logic [5:0] dbr_buf;  // Rising count, written value
		logic [5:0] dbf_buf;  // Falling count, written value
		logic [5:0] dbr_act;  // Rising count in use
		logic [5:0] dbf_act;  // Falling count in use
		logic [3:0] ovr;      // Override levels, BD then AC
		logic [7:0] rdata;    // Read data register
		logic       dat;      // Data input, previous cycle
		logic       osc_prev; // Oscillator, previous cycle
		logic       rev;      // Full-bridge direction in force
		logic       fb_ok;    // Direction dead band satisfied
		logic       pp;       // Push-pull: current pulse on B
		logic       keep_on;  // Oscillator keep-on request
		cwd_drive_t drv;      // Registered output drives
	} cwd_st_t;

	cwd_st_t     q;        // Register state
	cwd_st_t     d;        // Next state
	logic [14:0] sync;     // Synchronised sources and oscillator
	logic        din;      // Selected data input
	logic        rise;     // Data rising edge
	logic        fall;     // Data falling edge
	logic        tick;     // Dead-band clock edge
	logic        is_fb;    // Full-bridge mode
	logic        is_half;  // Half-bridge mode
	logic        new_rev;  // Direction asked by the mode
	logic        rev_now;  // Direction in force this cycle
	logic        sw;       // Direction switch at this edge
	logic        fbok_now; // Dead band satisfied this cycle
	logic        r_start;  // Rising counter start
	logic        r_hold;   // Rising counter hold
	logic        f_start;  // Falling counter start
	logic        f_hold;   // Falling counter hold
	logic        r_done;   // Rising dead band elapsed
	logic        f_done;   // Falling dead band elapsed
	logic        pp_now;   // Push-pull steering this cycle
	logic        xfer;     // Buffered counts move to active
	logic        ld_set;   // Software asks for a load
	logic        wr;       // Any register write
	logic [3:0]  w;        // Waveform, active high, before polarity
	logic [1:0]  lv;       // Override field of one output

	////////////////////////////////////////////////////////////////////
	// Input synchronisers and counters

	// Data sources and the oscillator pass two flip-flops first; sleep and shutdown do not
	cwd_sync u_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    ({osc_clk_i, src_i}),
		.sync_o     (sync)
	);

	// Rising-edge dead-band counter
	cwd_dbc u_dbr (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.start_i    (r_start),
		.hold_i     (r_hold),
		.tick_i     (tick),
		.limit_i    (q.dbr_act),
		.done_o     (r_done)
	);

	// Falling-edge dead-band counter
	cwd_dbc u_dbf (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.start_i    (f_start),
		.hold_i     (f_hold),
		.tick_i     (tick),
		.limit_i    (q.dbf_act),
		.done_o     (f_done)
	);

	////////////////////////////////////////////////////////////////////
	// Edge, clock and direction decode
	always_comb begin
		// Codes 14 and 15 select no source and read low
		din = (q.sel < 4'hE) ? sync[q.sel] : 1'b0;
		rise = din && !q.dat;
		fall = !din && q.dat;
		// System clock ticks every cycle; oscillator on its edge
		tick = q.cs ? (sync[14] && !q.osc_prev) : 1'b1;
		is_fb = (q.mode == CWD_M_FWD) || (q.mode == CWD_M_REV);
		is_half = (q.mode == CWD_M_HALF);
		new_rev = (q.mode == CWD_M_REV);
		// While enabled, direction follows the mode only at a data rising edge
		sw = q.en && is_fb && rise && (new_rev != q.rev);
		rev_now = sw ? new_rev : q.rev;
		fbok_now = sw ? 1'b0 : q.fb_ok;
		pp_now = rise ? !q.pp : q.pp;
	end

	////////////////////////////////////////////////////////////////////
	// Counter steering per mode
	always_comb begin
		r_start = 1'b0;
		r_hold = 1'b0;
		f_start = 1'b0;
		f_hold = 1'b0;
		if (q.en && is_half) begin
			// Rising band on data rise, falling band on data fall
			r_start = rise;
			r_hold = din;
			f_start = fall;
			f_hold = !din;
		end else if (q.en && is_fb) begin
			// Only after a direction change, on the modulated pulse
			r_start = rise;
			r_hold = din && rev_now && !fbok_now;
			f_start = rise;
			f_hold = din && !rev_now && !fbok_now;
		end
		// Push-pull and steering leave both counters idle
	end

	////////////////////////////////////////////////////////////////////
	// Waveform per mode, active high
	always_comb begin
		w = 4'h0;
		case (q.mode)
			CWD_M_HALF: begin
				// True and inverted copies with dead band
				w[0] = din && r_done;
				w[1] = !din && f_done;
				w[2] = w[0];
				w[3] = w[1];
			end
			CWD_M_FWD, CWD_M_REV: begin
				if (rev_now) begin
					// C on, B modulated, A and D off
					w[2] = 1'b1;
					w[1] = din && (fbok_now || r_done);
				end else begin
					// A on, D modulated, B and C off
					w[0] = 1'b1;
					w[3] = din && (fbok_now || f_done);
				end
			end
			CWD_M_PUSH: begin
				// Alternate pulses, first one on A, no dead band
				w[0] = din && !pp_now;
				w[1] = din && pp_now;
				w[2] = w[0];
				w[3] = w[1];
			end
			CWD_M_ASTEER, CWD_M_SSTEER: begin
				// Steering selection lives outside; all follow data
				w = {4{din}};
			end
			default: begin
				w = 4'h0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Next state: registers, load buffer, outputs
	always_comb begin
		d = q;
		lv = 2'b00;
		wr = bus_i.we;
		d.en_prev = q.en;
		d.dat = din;
		d.osc_prev = sync[14];
		// Register writes
		if (wr) begin
			case (bus_i.addr)
				`CWD_REG_CON0: begin
					d.en = bus_i.wdata[`CWD_EN_BIT];
					d.mode = cwd_mode_t'(bus_i.wdata[2:0]);
				end
				`CWD_REG_POL: d.pol = bus_i.wdata[3:0];
				`CWD_REG_DAT: d.sel = bus_i.wdata[3:0];
				`CWD_REG_CLK: d.cs = bus_i.wdata[`CWD_CS_BIT];
				`CWD_REG_DBR: d.dbr_buf = bus_i.wdata[5:0];
				`CWD_REG_DBF: d.dbf_buf = bus_i.wdata[5:0];
				`CWD_REG_OVR: d.ovr = bus_i.wdata[3:0];
				default: begin
					// Status and unmapped: writes ignored
				end
			endcase
		end
		// Disabled: write goes straight to the active count
		if (!q.en && wr && (bus_i.addr == `CWD_REG_DBR)) begin
			d.dbr_act = bus_i.wdata[5:0];
		end
		if (!q.en && wr && (bus_i.addr == `CWD_REG_DBF)) begin
			d.dbf_act = bus_i.wdata[5:0];
		end
		// Enabled: request, then falling edge, then rising edge
		ld_set = q.en && wr && (bus_i.addr == `CWD_REG_CON0) &&
			bus_i.wdata[`CWD_LD_BIT];
		xfer = q.ld && q.ld_armed && rise;
		if (xfer) begin
			d.dbr_act = q.dbr_buf;
			d.dbf_act = q.dbf_buf;
		end
		// Hardware clear loses to a fresh request
		d.ld = q.en && (ld_set || (q.ld && !xfer));
		if (!d.ld || xfer) begin
			d.ld_armed = 1'b0;
		end else if (q.ld && fall) begin
			d.ld_armed = 1'b1;
		end
		// Direction state and push-pull sequencer
		if (q.en) begin
			d.rev = rev_now;
			d.pp = pp_now;
			d.fb_ok = fbok_now || (rev_now ? r_done : f_done);
		end else begin
			// First entry into a direction needs no dead band
			d.rev = new_rev;
			d.pp = 1'b1;
			d.fb_ok = 1'b1;
		end
		// Keep the oscillator alive through sleep
		d.keep_on = q.en && q.cs && sleep_i;
		// Output drive
		d.drv.oe = 4'hF;
		if (!q.en || !q.en_prev) begin
			// Cleared drive while off and on the first enabled cycle
			d.drv.lvl = 4'h0;
		end else if (shutdown_i) begin
			// Override pairs A/C and B/D, no polarity
			for (int i = 0; i < 4; i++) begin
				lv = (i % 2 == 0) ? q.ovr[1:0] : q.ovr[3:2];
				d.drv.lvl[i] = lv[0];
				d.drv.oe[i] = !lv[`CWD_OVR_HIZ_BIT];
			end
		end else begin
			// Set polarity bit inverts to active-low
			d.drv.lvl = w ^ q.pol;
		end
		// Read data, valid in the cycle after the strobe
		d.rdata = 8'h00;
		if (bus_i.re) begin
			case (bus_i.addr)
				`CWD_REG_CON0: d.rdata = {q.en, q.ld, 3'b000, q.mode};
				`CWD_REG_POL: d.rdata = {4'h0, q.pol};
				`CWD_REG_DAT: d.rdata = {4'h0, q.sel};
				`CWD_REG_CLK: d.rdata = {7'h00, q.cs};
				`CWD_REG_DBR: d.rdata = {2'b00, q.dbr_buf};
				`CWD_REG_DBF: d.rdata = {2'b00, q.dbf_buf};
				`CWD_REG_OVR: d.rdata = {4'h0, q.ovr};
				`CWD_REG_STAT: d.rdata = {4'h0, q.ld_armed, q.fb_ok,
					q.rev, q.dat};
				default: d.rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register, synchronous reset
	// Data is sampled, so the seen band is N to N+1 periods
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.mode <= CWD_M_ASTEER;
			q.dbr_buf <= `CWD_RST_DB;
			q.dbf_buf <= `CWD_RST_DB;
			q.dbr_act <= `CWD_RST_DB;
			q.dbf_act <= `CWD_RST_DB;
			q.rdata <= `CWD_RST_BYTE;
			q.pp <= 1'b1;
			q.fb_ok <= 1'b1;
			q.drv.oe <= 4'hF;
		end else begin
			q <= d;
		end
	end

	assign rdata_o = q.rdata;
	assign osc_keep_on_o = q.keep_on;
	assign drive_o = q.drv;
endmodule

/* cwd_defines.svh */
// Register offsets, field positions and reset values of the dead-band unit
`ifndef CWD_DEFINES_SVH
`define CWD_DEFINES_SVH
`define CWD_ADDR_W      3
`define CWD_REG_CON0    3'h0
`define CWD_REG_POL     3'h1
`define CWD_REG_DAT     3'h2
`define CWD_REG_CLK     3'h3
`define CWD_REG_DBR     3'h4
`define CWD_REG_DBF     3'h5
`define CWD_REG_OVR     3'h6
`define CWD_REG_STAT    3'h7
`define CWD_EN_BIT      7
`define CWD_LD_BIT      6
`define CWD_CS_BIT      0
`define CWD_OVR_HIZ_BIT 1
`define CWD_NSRC        14
`define CWD_SYNC_W      15
`define CWD_DB_W        6
`define CWD_RST_BYTE    8'h00
`define CWD_RST_DB      6'h00
`endif

/* cwd_pkg.sv */
// Types shared by the dead-band unit modules
package cwd_pkg;
	// Operating modes, binary codes
	typedef enum logic [2:0] {
		CWD_M_ASTEER = 3'b000,
		CWD_M_SSTEER = 3'b001,
		CWD_M_FWD    = 3'b010,
		CWD_M_REV    = 3'b011,
		CWD_M_HALF   = 3'b100,
		CWD_M_PUSH   = 3'b101
	} cwd_mode_t;
	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} cwd_bus_req_t;
	// Four output levels with their enables
	typedef struct packed {
		logic [3:0] lvl;
		logic [3:0] oe;
	} cwd_drive_t;
	// Dead-band counter state
	typedef struct packed {
		logic [5:0] cnt;
		logic       done;
	} cwd_dbc_st_t;
	// Synchroniser state: 14 sources plus the oscillator
	typedef struct packed {
		logic [14:0] meta;
		logic [14:0] sync;
	} cwd_sync_st_t;
endpackage

/* cwd_sync.sv */
// Two-stage synchroniser bank for the asynchronous inputs
`timescale 1ns/1ps
`include "cwd_defines.svh"
module cwd_sync import cwd_pkg::*; (
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	input  wire logic [14:0] async_i,
	output logic      [14:0] sync_o
);
	cwd_sync_st_t st_q; // Register state
	cwd_sync_st_t st_d; // Next state
	genvar        gi;

	// Per bit: first stage feeds only the second stage
	generate
		for (gi = 0; gi < `CWD_SYNC_W; gi++) begin : g_bit
			assign st_d.meta[gi] = async_i[gi];
			assign st_d.sync[gi] = st_q.meta[gi];
		end
	endgenerate

	// State register, synchronous reset
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_o = st_q.sync;
endmodule

/* cwd_dbc.sv */
// One 6-bit dead-band counter with abort on input reversal
`timescale 1ns/1ps
module cwd_dbc import cwd_pkg::*; (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       start_i,  // Edge of the data input
	input  wire logic       hold_i,   // Level still calls for the output
	input  wire logic       tick_i,   // Dead-band clock rising edge
	input  wire logic [5:0] limit_i,  // Active count value
	output logic            done_o    // Dead band elapsed
);
	cwd_dbc_st_t st_q; // Register state
	cwd_dbc_st_t st_d; // Next state

	// Count from zero on each tick until the limit is met
	always_comb begin
		st_d = st_q;
		if (!hold_i || start_i) begin
			// Reversal aborts, edge restarts from zero
			st_d.cnt  = '0;
			st_d.done = 1'b0;
		end else if (tick_i && !st_q.done) begin
			st_d.cnt  = st_q.cnt + 6'h01;
			st_d.done = ((st_q.cnt + 6'h01) == limit_i);
		end
	end

	// State register, synchronous reset
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Zero count means no dead band at all
	assign done_o = hold_i && (st_q.done || (limit_i == 6'h00));
endmodule

/* cwd_core_asserts.sv */
// Port-level assertions of the dead-band core, bound to its top
`timescale 1ns/1ps
module cwd_core_asserts import cwd_pkg::*; (
	input wire logic         core_clk_i,
	input wire logic         rst_i,
	input wire cwd_bus_req_t bus_i,
	input wire logic   [7:0] rdata_o,
	input wire logic  [13:0] src_i,
	input wire logic         osc_clk_i,
	input wire logic         sleep_i,
	input wire logic         shutdown_i,
	input wire logic         osc_keep_on_o,
	input wire cwd_drive_t   drive_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////
	logic       en_q, cs_q, sel_q;      // Shadow enable, clock pick, data
	logic [2:0] mode_q;                 // Shadow mode
	logic [3:0] pol_q, dat_q, ovr_q;    // Shadow polarity, source, override
	logic [3:0] quiet_q, fb_q;          // Settle counters
	logic [5:0] dbr_q, dbf_q, dbw_q;    // Active counts, written rising count
	logic [6:0] rage_q, fage_q;         // Cycles since data rise / fall
	logic       sel, rise;              // Selected data and its rise
	logic [3:0] act;                    // Outputs with polarity removed
	assign sel  = src_i[dat_q];
	assign rise = sel && !sel_q;
	assign act  = drive_o.lvl ^ pol_q;
	// Shadows follow writes; counts load only while disabled, a known lower
	// bound once a buffered load is pending
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			{en_q, cs_q, sel_q, mode_q, pol_q, dat_q, ovr_q} <= '0;
			{quiet_q, fb_q, dbr_q, dbf_q, dbw_q} <= '0;
			{rage_q, fage_q} <= 14'h3FFF;
		end else begin
			sel_q   <= sel;
			quiet_q <= (bus_i.we || shutdown_i) ? 4'h0
				: quiet_q + {3'h0, quiet_q != 4'hF};
			rage_q  <= rise ? 7'h00 : rage_q + {6'h0, rage_q != 7'h7F};
			fage_q  <= (sel_q && !sel) ? 7'h00
				: fage_q + {6'h0, fage_q != 7'h7F};
			// Full-bridge statics settle some cycles after a data rise
			if (bus_i.we || shutdown_i || !en_q) fb_q <= 4'h0;
			else if (rise || fb_q != 4'h0) fb_q <= fb_q + {3'h0, fb_q != 4'hF};
			if (bus_i.we) begin
				case (bus_i.addr)
					3'h0: {en_q, mode_q} <= {bus_i.wdata[7], bus_i.wdata[2:0]};
					3'h1: pol_q <= bus_i.wdata[3:0];
					3'h2: dat_q <= bus_i.wdata[3:0];
					3'h3: cs_q <= bus_i.wdata[0];
					3'h4: dbw_q <= bus_i.wdata[5:0];
					3'h6: ovr_q <= bus_i.wdata[3:0];
					default: ;
				endcase
				if (bus_i.addr == 3'h4 && !en_q) dbr_q <= bus_i.wdata[5:0];
				if (bus_i.addr == 3'h5 && !en_q) dbf_q <= bus_i.wdata[5:0];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	a_dbr_read: assert property (
		bus_i.re && bus_i.addr == 3'h4 |=> rdata_o == {2'b00, dbw_q})
		else $error("rising count reads back wrong");
	a_keep_on: assert property (
		osc_keep_on_o == $past(en_q && cs_q && sleep_i))
		else $error("oscillator keep-on wrong");
	a_off_clear: assert property (
		!en_q && !$past(en_q) |-> drive_o == {4'h0, 4'hF})
		else $error("outputs not cleared while disabled");
	a_on_clear: assert property (
		en_q && !$past(en_q, 2) |-> drive_o == {4'h0, 4'hF})
		else $error("outputs not cleared after enabling");
	// Clear of the first enabled cycle outranks the override, so wait two
	a_ovr_level: assert property (
		en_q && $past(en_q) && $past(en_q, 2)
		&& shutdown_i && $past(shutdown_i)
		&& $stable(ovr_q) |-> drive_o.oe == ~{ovr_q[3], ovr_q[1], ovr_q[3],
		ovr_q[1]} && (drive_o.lvl & drive_o.oe) == ({ovr_q[2], ovr_q[0],
		ovr_q[2], ovr_q[0]} & drive_o.oe))
		else $error("override levels wrong in shutdown");
	a_fwd_static: assert property (
		en_q && mode_q == CWD_M_FWD && fb_q == 4'hF
		|-> act[0] && !act[1] && !act[2])
		else $error("forward static outputs wrong");
	a_rev_static: assert property (
		en_q && mode_q == CWD_M_REV && fb_q == 4'hF
		|-> act[2] && !act[0] && !act[3])
		else $error("reverse static outputs wrong");
	a_half_gap: assert property (
		en_q && mode_q == CWD_M_HALF && quiet_q == 4'hF |-> !(act[0] && act[1]))
		else $error("half-bridge outputs overlap");
	a_rise_band: assert property (
		en_q && mode_q == CWD_M_HALF && quiet_q == 4'hF && act[0]
		// Zero count bypasses the counter register, one cycle sooner
		|-> rage_q >= {1'b0, dbr_q} + ((dbr_q == 6'h00) ? 7'd2 : 7'd3))
		else $error("output A turned on inside rising band");
	a_fall_band: assert property (
		en_q && mode_q == CWD_M_HALF && quiet_q == 4'hF && act[1]
		|-> fage_q >= {1'b0, dbf_q} + ((dbf_q == 6'h00) ? 7'd2 : 7'd3))
		else $error("output B turned on inside falling band");
	a_zero_band: assert property (
		rise && en_q && mode_q == CWD_M_HALF && dbr_q == 6'h00
		&& quiet_q == 4'hF |-> ##[3:5] act[0])
		else $error("zero band output A late");
endmodule
bind cwd_core cwd_core_asserts u_chk (.core_clk_i(core_clk_i),
	.rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .src_i(src_i),
	.osc_clk_i(osc_clk_i), .sleep_i(sleep_i), .shutdown_i(shutdown_i),
	.osc_keep_on_o(osc_keep_on_o), .drive_o(drive_o));

/* cwd_sw_model.sv */
// Behavioural bridge switch drivers seen at the four output pins
`timescale 1ns/1ps
module cwd_sw_model import cwd_pkg::*; (
	input  wire logic       core_clk_i, // System clock
	input  wire logic       arm_i,      // Count overlap only when meaningful
	input  wire cwd_drive_t drive_i,    // Output drives of the core
	output logic      [3:0] pin_o,      // Pin levels, pull-down when released
	output int              shoot_o     // Cycles with leg A-B both on
);
	////////////////////////////////////////////////////////////////////////
	// Released pins fall to the pull-down, never keep the last level
	assign pin_o = drive_i.oe & drive_i.lvl;
	// Both switches of one leg on means shoot-through current
	initial shoot_o = 0;
	always @(posedge core_clk_i) begin
		if (arm_i && pin_o[0] && pin_o[1]) shoot_o <= shoot_o + 1;
	end
endmodule

/* cwd_core_tb.sv */
// Self-checking bench of the dead-band core
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module cwd_core_tb import cwd_pkg::*; ;
	typedef struct packed {
		logic [7:0] con; // Mode with enable
		logic [1:0] out; // Output that follows data
		logic [3:0] ext; // Extra band in cycles
	} cwd_row_t;
	logic         core_clk_i = 1'b0; // 40 MHz
	logic         rst_i      = 1'b1; // Held for 4 cycles
	cwd_bus_req_t bus_i      = '0;   // Register port
	logic  [13:0] src_i      = '0;   // Data sources, index 3 used
	logic         osc_clk_i  = 1'b0; // 16 MHz, free running
	logic         sleep_i    = 1'b0;
	logic         shutdown_i = 1'b0;
	logic         arm        = 1'b0; // Overlap watch on
	logic   [7:0] rdata_o;
	logic         osc_keep_on_o;
	cwd_drive_t   drive_o;
	logic   [3:0] pin;
	int           shoot, error_cnt = 0, comparisons = 0;
	// Every mode once; only half bridge adds the band here
	cwd_row_t rows [6] = '{'{8'h84, 2'd0, 4'd5}, '{8'h85, 2'd0, 4'd0},
		'{8'h80, 2'd0, 4'd0}, '{8'h81, 2'd0, 4'd0}, '{8'h82, 2'd3, 4'd0},
		'{8'h83, 2'd1, 4'd0}};
	always #12.5 core_clk_i = ~core_clk_i;
	always #31.25 osc_clk_i = ~osc_clk_i;
	////////////////////////////////////////////////////////////////////////
	cwd_core uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .src_i(src_i), .osc_clk_i(osc_clk_i),
		.sleep_i(sleep_i), .shutdown_i(shutdown_i),
		.osc_keep_on_o(osc_keep_on_o), .drive_o(drive_o));
	cwd_sw_model u_sw (.core_clk_i(core_clk_i), .arm_i(arm),
		.drive_i(drive_o), .pin_o(pin), .shoot_o(shoot));
	////////////////////////////////////////////////////////////////////////
	// One-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		bus_i.addr  <= a;
		bus_i.wdata <= d;
		bus_i.we    <= 1'b1;
		@(posedge core_clk_i);
		bus_i.we    <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		bus_i.addr <= a;
		bus_i.re   <= 1'b1;
		@(posedge core_clk_i);
		bus_i.re   <= 1'b0;
		#1 d = rdata_o;
	endtask
	// Mode is set while disabled, then enabled
	task automatic cfg(input logic [7:0] con, pol, dbr, dbf);
		wr(3'h0, con & 8'h7F);
		wr(3'h1, pol);
		wr(3'h4, dbr);
		wr(3'h5, dbf);
		wr(3'h0, con);
	endtask
	// Quiet low, then high and low for hi cycles; first active cycles
	task automatic pulse(input int br, bf, hi, output int lr, lf);
		lr = -1;
		lf = -1;
		repeat (16) @(posedge core_clk_i);
		src_i[3] <= 1'b1;
		for (int i = 1; i <= 2 * hi; i++) begin
			@(posedge core_clk_i);
			if (i == hi) src_i[3] <= 1'b0;
			#1;
			if (i <= hi && lr < 0 && pin[br] === 1'b1) lr = i;
			if (i > hi && lf < 0 && pin[bf] === 1'b1) lf = i - hi;
		end
	endtask
	// Four cycles plus band, one cycle of slack either way
	task automatic win(input int v, input int lo);
		`CHK(v >= lo && v <= lo + 2, 1'b1)
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence: reset reads, then table, awkward cases after
	initial begin
		int lr, lf;
		logic [7:0] d;
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 7; a++) begin
			rd(3'(a), d);
			`CHK(d, 8'h00)
		end
		`CHK(drive_o, 8'h0F)
		$display("test reset done");
		wr(3'h2, 8'h03);
		foreach (rows[k]) begin
			cfg(rows[k].con, 8'h00, 8'h05, 8'h05);
			pulse(rows[k].out, 1, 20, lr, lf);
			win(lr, 3 + rows[k].ext);
		end
		$display("test mode table done");
		arm = 1'b1;
		cfg(8'h84, 8'h00, 8'h00, 8'h00);
		pulse(0, 1, 20, lr, lf);
		win(lr, 3);
		win(lf, 3);
		cfg(8'h84, 8'h00, 8'h03, 8'h02);
		pulse(0, 1, 20, lr, lf);
		win(lr, 6);
		win(lf, 5);
		cfg(8'h84, 8'h00, 8'h08, 8'h08);
		pulse(0, 1, 4, lr, lf);
		`CHK(lr, -1)
		$display("test half bridge done");
		// Direction changes while enabled
		cfg(8'h82, 8'h00, 8'h06, 8'h03);
		pulse(3, 0, 20, lr, lf);
		win(lr, 3);
		wr(3'h0, 8'h83);
		pulse(1, 0, 20, lr, lf);
		win(lr, 9);
		pulse(1, 0, 20, lr, lf);
		win(lr, 3);
		wr(3'h0, 8'h82);
		pulse(3, 0, 20, lr, lf);
		win(lr, 6);
		$display("test direction done");
		// Buffered counts while enabled
		cfg(8'h84, 8'h00, 8'h02, 8'h02);
		wr(3'h4, 8'h0A);
		pulse(0, 1, 20, lr, lf);
		win(lr, 5);
		wr(3'h0, 8'hC4);
		rd(3'h0, d);
		`CHK(d, 8'hC4)
		pulse(0, 1, 20, lr, lf);
		pulse(0, 1, 20, lr, lf);
		rd(3'h0, d);
		`CHK(d, 8'h84)
		pulse(0, 1, 20, lr, lf);
		win(lr, 13);
		$display("test buffered load done");
		// Oscillator as band clock, kept on in sleep
		wr(3'h3, 8'h01);
		cfg(8'h84, 8'h00, 8'h04, 8'h04);
		pulse(0, 1, 30, lr, lf);
		`CHK(lr >= 12 && lr <= 20, 1'b1)
		@(posedge core_clk_i) sleep_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1 `CHK(osc_keep_on_o, 1'b1)
		wr(3'h3, 8'h00);
		repeat (2) @(posedge core_clk_i);
		#1 `CHK(osc_keep_on_o, 1'b0)
		@(posedge core_clk_i) sleep_i <= 1'b0;
		$display("test clock select done");
		// Overrides ignore polarity
		cfg(8'h82, 8'h0F, 8'h00, 8'h00);
		wr(3'h6, 8'h04);
		@(posedge core_clk_i) shutdown_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1 `CHK(drive_o, 8'hAF)
		wr(3'h6, 8'h02);
		repeat (2) @(posedge core_clk_i);
		#1 `CHK(drive_o.oe, 4'hA)
		@(posedge core_clk_i) shutdown_i <= 1'b0;
		$display("test shutdown done");
		// All outputs active-low: both high means both off
		arm = 1'b0;
		cfg(8'h84, 8'h0F, 8'h02, 8'h02);
		pulse(0, 1, 10, lr, lf);
		repeat (8) @(posedge core_clk_i);
		#1 `CHK(drive_o.lvl[1:0], 2'b01)
		`CHK(shoot, 0)
		$display("test polarity done");
		tally_and_finish();
	end
	// Watchdog well beyond the roughly 1200 cycles the tests need
	initial begin
		repeat (20000) @(posedge core_clk_i);
		error_cnt++;
		tally_and_finish();
	end
endmodule
